// ===== design/tws_pkg.sv
`default_nettype none
package tws_pkg;
    // ------------------------------------------------------------
    // widths and function codes
    // ------------------------------------------------------------
    localparam int NUM_INPUTS = 8;
    localparam int CODE_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [CODE_W-1:0] CODE_START = 8'h1C;
    localparam logic [CODE_W-1:0] CODE_STOP = 8'h1D;
    localparam logic [CODE_W-1:0] CODE_GEN_ENABLE = 8'h02;
    localparam logic [CODE_W-1:0] SRC_EMBEDDED = 8'h04;
    localparam logic [CODE_W-1:0] REMOTE_SRC_DEFAULT = 8'h01;
    localparam logic [CODE_W-1:0] LOCAL_SRC_RESET = 8'h00;
    localparam logic [CODE_W-1:0] FUNC_SEL_RESET = 8'h00;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_FUNC_SEL0 = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_FUNC_SEL7 = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_LOCAL_SRC = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_REMOTE_SRC = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h2C;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h34;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_IN_USE = 0;
    localparam int CTL_LOCAL_EN = 1;
    localparam int CTL_REMOTE_EN = 2;
    localparam int CTL_LOCAL_MODE = 3;
    localparam int CTL_W = 4;
    localparam logic [CTL_W-1:0] CTL_RESET = 4'h0;
    localparam int ST_RUN = 0;
    localparam int ST_ALARM = 1;
    localparam int ST_GEN = 2;
    localparam int ST_DRIVE = 3;
    localparam int ST_CONFIGURATION_ERROR_STATE = 4;
    localparam int ST_W = 5;
    localparam int EV_RUN_SET = 0;
    localparam int EV_RUN_CLR = 1;
    localparam int EV_ALARM = 2;
    localparam int EV_CONFIGURATION_ERROR_STATE = 3;
    localparam int EV_W = 4;
    localparam logic [EV_W-1:0] EV_RESET = 4'h0;
endpackage : tws_pkg
`default_nettype wire

// ===== design/tws_input_select.sv
`default_nettype none
// picks the level of the lowest-numbered input whose function code matches
module tws_input_select
    import tws_pkg::*;
#(
    parameter int N = NUM_INPUTS,
    parameter int W = CODE_W
) (
    input wire logic [N*W-1:0] func_sel,
    input wire logic [W-1:0] code,
    input wire logic [N-1:0] inputs,
    output logic found,
    output logic level
);
    logic [N-1:0] match;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_match
            assign match[g] = (func_sel[g*W +: W] == code);
        end
    endgenerate

    always_comb begin
        found = 1'b0;
        level = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (match[i]) begin
                found = 1'b1;
                level = inputs[i];
            end
        end
    end
endmodule // tws_input_select
`default_nettype wire

// ===== design/tws_three_wire.sv
// The plain strobed port and the placing of the registers were left to the implementer.
`default_nettype none
module tws_three_wire
    import tws_pkg::*;
#(
    parameter int N = NUM_INPUTS
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [N-1:0] digital_in,
    input wire logic fault,
    input wire logic undervoltage,
    input wire logic application_alarm,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic ramp_enable,
    output logic run_stop_source_alarm,
    output logic general_enable,
    output logic drive_enable,
    output logic configuration_error_state,
    output logic irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [N*CODE_W-1:0] func_sel;
    logic [CODE_W-1:0] local_run_stop_source;
    logic [CODE_W-1:0] remote_run_stop_source;
    logic [CTL_W-1:0] control;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_mask;

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    logic [N-1:0] din_meta;
    logic [N-1:0] din_sync;
    logic start_prev;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            din_meta <= '0;
            din_sync <= '0;
        end else if (ce) begin
            din_meta <= digital_in;
            din_sync <= din_meta;
        end
    end

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    logic start_found;
    logic start_lvl;
    logic stop_found;
    logic stop_lvl;
    logic gen_found;
    logic gen_lvl;

    tws_input_select #(.N(N), .W(CODE_W)) u_start_sel (
        .func_sel(func_sel),
        .code(CODE_START),
        .inputs(din_sync),
        .found(start_found),
        .level(start_lvl)
    );

    tws_input_select #(.N(N), .W(CODE_W)) u_stop_sel (
        .func_sel(func_sel),
        .code(CODE_STOP),
        .inputs(din_sync),
        .found(stop_found),
        .level(stop_lvl)
    );

    tws_input_select #(.N(N), .W(CODE_W)) u_gen_sel (
        .func_sel(func_sel),
        .code(CODE_GEN_ENABLE),
        .inputs(din_sync),
        .found(gen_found),
        .level(gen_lvl)
    );

    // ------------------------------------------------------------
    // run latch and enables
    // ------------------------------------------------------------
    // high level means asserted
    wire start_act = start_found & start_lvl;
    wire stop_act = stop_found & stop_lvl;
    wire start_rise = start_act & ~start_prev;
    // latch on start, drop on stop release; stop wins
    wire next_run = stop_act & (ramp_enable | start_rise);
    wire next_alarm = control[CTL_IN_USE] & (local_run_stop_source != SRC_EMBEDDED)
                      & (remote_run_stop_source != SRC_EMBEDDED);
    wire mode_en = control[CTL_LOCAL_EN] | control[CTL_REMOTE_EN];
    wire next_gen = mode_en & ~fault & ~undervoltage & ~application_alarm & ~next_alarm;
    wire next_drive = next_gen & (~gen_found | gen_lvl);
    // input one used in local mode while remote source untouched
    wire in1_code_hit = (func_sel[CODE_W-1:0] == CODE_START) | (func_sel[CODE_W-1:0] == CODE_STOP);
    wire next_configuration_error_state = control[CTL_IN_USE] & control[CTL_LOCAL_MODE] & in1_code_hit
                     & (remote_run_stop_source == REMOTE_SRC_DEFAULT);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            start_prev <= 1'b0;
            ramp_enable <= 1'b0;
            run_stop_source_alarm <= 1'b0;
            general_enable <= 1'b0;
            drive_enable <= 1'b0;
            configuration_error_state <= 1'b0;
        end else if (ce) begin
            start_prev <= start_act;
            ramp_enable <= next_run;
            run_stop_source_alarm <= next_alarm;
            general_enable <= next_gen;
            drive_enable <= next_drive;
            configuration_error_state <= next_configuration_error_state;
        end
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    wire func_hit = (reg_addr <= ADDR_FUNC_SEL7) && (reg_addr[1:0] == 2'b00);
    wire [2:0] func_idx = reg_addr[4:2];
    wire local_hit = (reg_addr == ADDR_LOCAL_SRC);
    wire remote_hit = (reg_addr == ADDR_REMOTE_SRC);
    wire ctl_hit = (reg_addr == ADDR_CONTROL);
    wire state_hit = (reg_addr == ADDR_STATE);
    wire ists_hit = (reg_addr == ADDR_IRQ_STATUS);
    wire imask_hit = (reg_addr == ADDR_IRQ_MASK);
    wire [ST_W-1:0] state_word = {configuration_error_state, drive_enable, general_enable,
                                  run_stop_source_alarm, ramp_enable};
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (func_hit) begin
            rd_mux[CODE_W-1:0] = func_sel[func_idx*CODE_W +: CODE_W];
        end else if (local_hit) begin
            rd_mux[CODE_W-1:0] = local_run_stop_source;
        end else if (remote_hit) begin
            rd_mux[CODE_W-1:0] = remote_run_stop_source;
        end else if (ctl_hit) begin
            rd_mux[CTL_W-1:0] = control;
        end else if (state_hit) begin
            rd_mux[ST_W-1:0] = state_word;
        end else if (ists_hit) begin
            rd_mux[EV_W-1:0] = irq_status;
        end else if (imask_hit) begin
            rd_mux[EV_W-1:0] = irq_mask;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_func
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    func_sel[g*CODE_W +: CODE_W] <= FUNC_SEL_RESET;
                end else if (ce && reg_wr && func_hit && func_idx == 3'(g)) begin
                    func_sel[g*CODE_W +: CODE_W] <= reg_wdata[CODE_W-1:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            local_run_stop_source <= LOCAL_SRC_RESET;
            remote_run_stop_source <= REMOTE_SRC_DEFAULT;
            control <= CTL_RESET;
            irq_mask <= EV_RESET;
        end else if (ce && reg_wr) begin
            if (local_hit) begin
                local_run_stop_source <= reg_wdata[CODE_W-1:0];
            end
            if (remote_hit) begin
                remote_run_stop_source <= reg_wdata[CODE_W-1:0];
            end
            if (ctl_hit) begin
                control <= reg_wdata[CTL_W-1:0];
            end
            if (imask_hit) begin
                irq_mask <= reg_wdata[EV_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire [EV_W-1:0] events = {next_configuration_error_state & ~configuration_error_state,
                              next_alarm & ~run_stop_source_alarm,
                              ramp_enable & ~next_run,
                              next_run & ~ramp_enable};
    wire [EV_W-1:0] w1c = (ce && reg_wr && ists_hit) ? reg_wdata[EV_W-1:0] : EV_RESET;
    // a new event beats a clear in the same cycle
    wire [EV_W-1:0] next_status = (irq_status & ~w1c) | events;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_status <= EV_RESET;
            irq <= 1'b0;
        end else if (ce) begin
            irq_status <= next_status;
            irq <= |(next_status & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    run_latch_a: assert property (ce && stop_act && start_rise |=> ramp_enable)
        else $error("start pulse with stop active did not set run");
    run_drop_a: assert property (ce && !stop_act |=> !ramp_enable)
        else $error("run held while stop inactive");
    source_alarm_a: assert property ((ce && next_alarm) |=> run_stop_source_alarm)
        else $error("source alarm missing");
    alarm_clear_a: assert property ((ce && control[CTL_IN_USE]
        && local_run_stop_source == SRC_EMBEDDED) |=> !run_stop_source_alarm)
        else $error("source alarm raised with embedded source");
    start_pick_a: assert property (func_sel[CODE_W-1:0] == CODE_START |-> start_lvl == din_sync[0])
        else $error("start not taken from highest priority input");
    stop_pick_a: assert property (func_sel[CODE_W-1:0] == CODE_STOP |-> stop_lvl == din_sync[0])
        else $error("stop not taken from highest priority input");
    gen_fault_a: assert property (ce && (fault || undervoltage) |=> !general_enable)
        else $error("general enable with fault present");
    drive_gate_a: assert property (drive_enable |-> general_enable)
        else $error("drive enabled without general enable");
    configuration_error_state_state_a: assert property (ce && next_configuration_error_state |=> configuration_error_state)
        else $error("configuration error not flagged");
    stop_wins_a: assert property (ce && start_rise && !stop_act |=> !ramp_enable)
        else $error("start overrode inactive stop");
    hold_a: assert property (!ce |=> $stable(ramp_enable) && $stable(irq_status))
        else $error("state moved while clock enable low");
    // a clear in the same cycle as an event must not swallow it
    event_wins_a: assert property (ce && (|events) |=> (irq_status & $past(events)) == $past(events))
        else $error("event lost to a same-cycle clear");
    irq_level_a: assert property (ce |=> irq == |(irq_status & $past(irq_mask)))
        else $error("interrupt output disagrees with status and mask");
    rdata_idle_a: assert property (ce && !reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside a read");
    gen_alarm_a: assert property (ce && next_alarm |=> !general_enable)
        else $error("general enable with source alarm");
    drive_off_a: assert property (ce && gen_found && !gen_lvl |=> !drive_enable)
        else $error("drive enabled with its enable input low");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    run_cycle_c: cover property (ce && start_rise && stop_act ##1 ramp_enable ##[1:20] !ramp_enable);
    drive_block_c: cover property (gen_found && general_enable && !drive_enable);
    alarm_c: cover property (run_stop_source_alarm ##1 irq);
    drive_c: cover property (gen_found && drive_enable);
    configuration_error_state_c: cover property ($rose(configuration_error_state));
endmodule // tws_three_wire
`default_nettype wire

// ===== dv/tws_field_contacts.sv
`default_nettype none
// push-buttons and retention contacts wired to chosen inputs
module tws_field_contacts
    import tws_pkg::*;
(
    input wire logic core_clk,
    input wire logic [2:0] start_pin,
    input wire logic [2:0] stop_pin,
    input wire logic [2:0] enable_pin,
    input wire logic start_btn,
    input wire logic stop_btn,
    input wire logic enable_btn,
    output logic [NUM_INPUTS-1:0] digital_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NUM_INPUTS-1:0] noise = '0;
    // unwired inputs change every cycle so a wrong pick shows
    always @(posedge core_clk) begin
        noise <= NUM_INPUTS'($urandom);
    end
    always_comb begin
        digital_in = noise;
        digital_in[enable_pin] = enable_btn;
        digital_in[stop_pin] = stop_btn;
        digital_in[start_pin] = start_btn;
    end
endmodule // tws_field_contacts
`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tws_pkg::*;
    logic core_clk = 1'b0;
    logic ce = 1'b1;
    logic rstn = 1'b0;
    logic fault = 1'b0;
    logic undervoltage = 1'b0;
    logic application_alarm = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic ramp_enable, run_stop_source_alarm, general_enable, drive_enable, configuration_error_state, irq;
    logic [NUM_INPUTS-1:0] digital_in;
    logic [2:0] start_pin = 3'h0, stop_pin = 3'h1, enable_pin = 3'h2, p;
    logic start_btn = 1'b0, stop_btn = 1'b0, enable_btn = 1'b0, sw;
    logic [31:0] snap;
    int fail_count = 0;
    int n_tests = 0;
    always #12.5 core_clk = ~core_clk;
    // values settled half a cycle after the edge, read race-free at the next edge
    always @(negedge core_clk) begin
        snap <= {26'h0, irq, configuration_error_state, drive_enable, general_enable,
                 run_stop_source_alarm, ramp_enable};
    end
    tws_field_contacts u_field (.core_clk(core_clk), .start_pin(start_pin), .stop_pin(stop_pin),
        .enable_pin(enable_pin), .start_btn(start_btn), .stop_btn(stop_btn),
        .enable_btn(enable_btn), .digital_in(digital_in));
    tws_three_wire DUT (.core_clk(core_clk), .rstn(rstn), .ce(ce), .digital_in(digital_in),
        .fault(fault), .undervoltage(undervoltage), .application_alarm(application_alarm),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ramp_enable(ramp_enable), .run_stop_source_alarm(run_stop_source_alarm),
        .general_enable(general_enable), .drive_enable(drive_enable),
        .configuration_error_state(configuration_error_state), .irq(irq));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] exp_outs(input logic run, input logic en_in);
        // general enable up, source alarm off in every trial
        return {28'h0, en_in, 1'b1, 1'b0, run};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #(25 * 30000);
        fail_count++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(40441));
        cyc(20);
        rstn <= 1'b1;
        rdc(ADDR_REMOTE_SRC, 32'h0000_0001);
        rdc(8'h40, 32'h0000_0000);
        wr(ADDR_CONTROL, 32'h0000_0005);
        cyc(6);
        chk(snap, 32'h0000_0002);
        wr(ADDR_LOCAL_SRC, 32'h0000_0004);
        cyc(6);
        chk(snap, 32'h0000_000C);
        wr(ADDR_LOCAL_SRC, 32'h0000_0000);
        wr(ADDR_REMOTE_SRC, 32'h0000_0004);
        cyc(6);
        chk(snap, 32'h0000_000C);
        $display("source alarm test done");
        for (int k = 0; k < 4; k++) begin
            {application_alarm, undervoltage, fault} <= 3'(1 << k);
            if (k == 3) wr(ADDR_CONTROL, 32'h0000_0001);
            cyc(6);
            chk(snap[3:2], 2'b00);
        end
        wr(ADDR_CONTROL, 32'h0000_0003);
        cyc(6);
        chk(snap, 32'h0000_000C);
        $display("general enable test done");
        for (int t = 0; t < 12; t++) begin
            p = 3'($urandom_range(0, 5));
            sw = 1'($urandom);
            start_pin <= sw ? p : p + 3'h1;
            stop_pin <= sw ? p + 3'h1 : p;
            enable_pin <= p + 3'h2;
            for (int k = 0; k < 8; k++) begin
                // higher duplicates carry noise and must lose to the real contact
                wr(ADDR_FUNC_SEL0 + 8'(4 * k), k < p ? 32'h0 : k == p ? (sw ? CODE_START : CODE_STOP) :
                   k == p + 1 ? (sw ? CODE_STOP : CODE_START) : k == p + 2 ? CODE_GEN_ENABLE :
                   ($urandom_range(0, 1) ? CODE_START : CODE_STOP));
            end
            start_btn <= 1'b0;
            stop_btn <= 1'b0;
            enable_btn <= 1'($urandom);
            cyc(6);
            chk(snap, exp_outs(1'b0, enable_btn));
            start_btn <= 1'b1;
            cyc(2);
            start_btn <= 1'b0;
            cyc(6);
            chk(snap, exp_outs(1'b0, enable_btn));
            stop_btn <= 1'b1;
            cyc(5);
            start_btn <= 1'b1;
            cyc(1);
            chk(snap[0], 1'b0);
            cyc(5);
            chk(snap, exp_outs(1'b1, enable_btn));
            stop_btn <= 1'b0;
            cyc(6);
            chk(snap, exp_outs(1'b0, enable_btn));
            stop_btn <= 1'b1;
            cyc(6);
            chk(snap[0], 1'b0);
            start_btn <= 1'b0;
            cyc(2);
        end
        $display("start stop trials done");
        wr(ADDR_IRQ_MASK, 32'h0000_0001);
        cyc(4);
        chk(snap[5], 1'b1);
        rdc(ADDR_IRQ_STATUS, 32'h0000_0007);
        wr(ADDR_IRQ_STATUS, 32'h0000_0007);
        cyc(4);
        chk(snap[5], 1'b0);
        start_btn <= 1'b1;
        cyc(6);
        chk(snap[5], 1'b1);
        wr(ADDR_IRQ_MASK, 32'h0000_0000);
        cyc(4);
        chk(snap[5], 1'b0);
        rdc(ADDR_IRQ_STATUS, 32'h0000_0001);
        $display("interrupt test done");
        // a frozen clock enable keeps run although stop drops
        cyc(1);
        ce <= 1'b0;
        stop_btn <= 1'b0;
        cyc(6);
        chk(snap[0], 1'b1);
        ce <= 1'b1;
        cyc(6);
        chk(snap[0], 1'b0);
        stop_btn <= 1'b1;
        $display("clock enable test done");
        wr(ADDR_FUNC_SEL0, {24'h0, CODE_STOP});
        wr(ADDR_REMOTE_SRC, 32'h0000_0001);
        wr(ADDR_CONTROL, 32'h0000_0009);
        cyc(6);
        chk(snap[4], 1'b1);
        wr(ADDR_IRQ_MASK, 32'h0000_0008);
        cyc(2);
        chk(snap[5], 1'b1);
        wr(ADDR_REMOTE_SRC, 32'h0000_0004);
        cyc(6);
        chk(snap[4], 1'b0);
        $display("configuration error test done");
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
